// ===== common/sts_map.vh
// Register map, field layout and timing constants of the shock sequencer
`ifndef STS_MAP_VH
`define STS_MAP_VH
// Register byte addresses
`define STS_REG_CTRL 8'h00
`define STS_REG_STATUS 8'h04
`define STS_REG_EPISODE 8'h08
`define STS_REG_ZCFG0 8'h10
`define STS_REG_ENERGY0 8'h40
`define STS_REG_ENERGY_END 8'h9c
// Control fields
`define STS_CTRL_ENABLE 0
`define STS_CTRL_SEPARATE 1
// Zone config fields
`define STS_ZCFG_SHOCK_EN 0
`define STS_ZCFG_CONFIRM 1
`define STS_ZCFG_WAVE_LO 2
`define STS_ZCFG_POL_LO 4
`define STS_ZCFG_PATH_LO 6
`define STS_ZCFG_RESET 8'h03
// Classification codes from detection
`define STS_CLS_SINUS 3'h0
`define STS_CLS_BRADY 3'h1
`define STS_CLS_BELOW 3'h2
`define STS_CLS_SLOW 3'h3
`define STS_CLS_MID 3'h4
`define STS_CLS_FIB 3'h5
// Zone numbers
`define STS_ZONE_SLOW 2'h0
`define STS_ZONE_FIB 2'h2
// Shock sequence limits
`define STS_SHOCKS 4'h8
`define STS_SKIP_POS 3'h2
`define STS_ABORT_HITS 3'h3
`define STS_MIN_JOULES 8'h02
// Times in their own units and clock rate
`define STS_CLK_MHZ 125
`define STS_WINDOW_MS 2000
`define STS_PHASE1_US 23000
`define STS_PAUSE_US 1000
`define STS_PHASE2_US 17000
`define STS_BLANK_MS 1000
`endif

// ===== design/sts_sequencer.v
// Shock therapy sequencer with Avalon-MM register slave
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "sts_map.vh"
module sts_sequencer #(
  parameter MAX_JOULES = 8'd40,
  parameter WINDOW_CYC = `STS_WINDOW_MS * `STS_CLK_MHZ * 1000,
  parameter PHASE1_CYC = `STS_PHASE1_US * `STS_CLK_MHZ,
  parameter PAUSE_CYC = `STS_PAUSE_US * `STS_CLK_MHZ,
  parameter PHASE2_CYC = `STS_PHASE2_US * `STS_CLK_MHZ,
  parameter BLANK_CYC = `STS_BLANK_MS * `STS_CLK_MHZ * 1000
) (
  // Clock, reset, enable
  input wire clock,
  input wire reset_n,
  input wire ce,
  // Avalon-MM slave
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  // Detection unit
  input wire class_valid,
  input wire [2:0] class_code,
  input wire episode_end,
  input wire r_wave,
  input wire asystole,
  input wire accel_detected,
  // High-voltage stage
  input wire charge_done,
  input wire phase_done,
  output reg charge_on,
  output reg dump,
  output reg fire,
  output reg fire_unsync,
  output reg [1:0] shock_phase,
  output reg [7:0] shock_energy,
  output reg shock_polarity,
  output reg shock_waveform,
  output reg [1:0] shock_path,
  // Pacing and therapy status
  output reg blanking,
  output reg post_shock_pace,
  output reg atp_blocked,
  output reg therapy_done
);
  localparam S_IDLE = 3'h0;
  localparam S_CHARGE = 3'h1;
  localparam S_WAIT = 3'h2;
  localparam S_SHOCK = 3'h3;
  localparam S_BLANK = 3'h4;
  localparam S_POST = 3'h5;
  localparam S_DUMP = 3'h6;

  reg [2:0] state;
  reg [1:0] ctrl;
  reg [7:0] zcfg [0:2];
  reg [7:0] energy_mem [0:23];
  reg ack;
  reg [1:0] zone;
  reg [2:0] pos;
  reg [3:0] delivered;
  reg [3:0] max_count;
  reg [7:0] last_energy;
  reg [3:0] history;
  reg veto;
  reg shocked;
  reg [2:0] zone_block;
  reg [31:0] timer;
  integer i;

  // Decoded request and event classes
  wire req = read | write;
  wire is_tach = (class_code == `STS_CLS_SLOW) | (class_code == `STS_CLS_MID) |
    (class_code == `STS_CLS_FIB);
  wire is_slowish = (class_code == `STS_CLS_SINUS) | (class_code == `STS_CLS_BRADY);
  wire [1:0] ev_zone = class_code[1:0] - 2'h3;
  wire [7:0] cfg = zcfg[ctrl[`STS_CTRL_SEPARATE] ? zone : `STS_ZONE_FIB];
  wire [7:0] ev_cfg = zcfg[ctrl[`STS_CTRL_SEPARATE] ? ev_zone : `STS_ZONE_FIB];
  wire confirm = cfg[`STS_ZCFG_CONFIRM];
  wire [2:0] hits = {2'h0, history[0]} + {2'h0, history[1]} +
    {2'h0, history[2]} + {2'h0, history[3]};
  wire abort_met = hits >= `STS_ABORT_HITS;
  wire mem_hit = address >= `STS_REG_ENERGY0 && address <= `STS_REG_ENERGY_END;
  wire [7:0] mem_off = address - `STS_REG_ENERGY0;
  wire [4:0] mem_idx = mem_off[6:2];
  wire zcfg_hit = address[7:4] == 4'h1 && address[3:2] != 2'h3;

  // One wait cycle on every access, answer in the next
  assign waitrequest = req & ~ack;

  // Energy of the pending shock
  reg [7:0] prog_e;
  reg [7:0] next_energy;
  reg flip_pol;
  reg flip_wave;
  always @*
  begin
    prog_e = energy_mem[{zone, 3'h0} + {2'h0, pos}];
    if (prog_e < `STS_MIN_JOULES)
      prog_e = `STS_MIN_JOULES;
    if (prog_e > MAX_JOULES)
      prog_e = MAX_JOULES;
    next_energy = (pos < `STS_SKIP_POS) ? prog_e : MAX_JOULES;
    if (next_energy < last_energy)
      next_energy = last_energy;
    // Alternation starts with the second maximum-energy shock
    flip_pol = 1'b0;
    flip_wave = 1'b0;
    if (next_energy == MAX_JOULES)
    begin
      if (cfg[`STS_ZCFG_POL_LO + 1] && cfg[`STS_ZCFG_WAVE_LO + 1])
      begin
        flip_pol = max_count[0];
        flip_wave = max_count[1];
      end
      else
      begin
        flip_pol = cfg[`STS_ZCFG_POL_LO + 1] & max_count[0];
        flip_wave = cfg[`STS_ZCFG_WAVE_LO + 1] & max_count[0];
      end
    end
  end

  // Register writes and bus acknowledge
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack <= 1'b0;
      ctrl <= 2'h0;
      readdata <= 32'h0;
      for (i = 0; i < 3; i = i + 1)
        zcfg[i] <= `STS_ZCFG_RESET;
      for (i = 0; i < 24; i = i + 1)
        energy_mem[i] <= `STS_MIN_JOULES;
    end
    else if (ce)
    begin
      ack <= req & ~ack;
      if (req && !ack)
      begin
        // Read data is captured now so it stands at the answer edge
        readdata <= 32'h0;
        if (address == `STS_REG_CTRL)
          readdata <= {30'h0, ctrl};
        else if (address == `STS_REG_STATUS)
          readdata <= {15'h0, zone_block, therapy_done, atp_blocked, shocked, zone, 1'b0, history, veto, state};
        else if (address == `STS_REG_EPISODE)
          readdata <= {13'h0, pos, max_count, delivered, last_energy};
        else if (zcfg_hit)
          readdata <= {24'h0, zcfg[address[3:2]]};
        else if (mem_hit)
          readdata <= {24'h0, energy_mem[mem_idx]};
      end
      // Write lands at the answer edge, while the master still holds it
      if (write && ack)
      begin
        if (address == `STS_REG_CTRL)
          ctrl <= writedata[1:0];
        else if (zcfg_hit)
          zcfg[address[3:2]] <= writedata[7:0];
        else if (mem_hit)
          energy_mem[mem_idx] <= writedata[7:0];
      end
    end
  end

  // Therapy sequencer
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= S_IDLE;
      zone <= 2'h0;
      pos <= 3'h0;
      delivered <= 4'h0;
      max_count <= 4'h0;
      last_energy <= 8'h0;
      history <= 4'h0;
      veto <= 1'b0;
      shocked <= 1'b0;
      zone_block <= 3'h0;
      timer <= 32'h0;
      charge_on <= 1'b0;
      dump <= 1'b0;
      fire <= 1'b0;
      fire_unsync <= 1'b0;
      shock_phase <= 2'h0;
      shock_energy <= 8'h0;
      shock_polarity <= 1'b0;
      shock_waveform <= 1'b0;
      shock_path <= 2'h0;
      blanking <= 1'b0;
      post_shock_pace <= 1'b0;
      atp_blocked <= 1'b0;
      therapy_done <= 1'b0;
    end
    else if (ce)
    begin
      fire <= 1'b0;
      dump <= 1'b0;
      case (state)
        S_IDLE, S_POST:
        begin
          post_shock_pace <= (state == S_POST) &&
            (asystole || (class_valid && class_code == `STS_CLS_BRADY)) ? 1'b1 :
            (class_valid ? 1'b0 : post_shock_pace);
          if (state == S_POST && episode_end)
          begin
            // Termination closes the episode
            state <= S_IDLE;
            post_shock_pace <= 1'b0;
            shocked <= 1'b0;
            atp_blocked <= 1'b0;
            zone_block <= 3'h0;
            delivered <= 4'h0;
            pos <= 3'h0;
            max_count <= 4'h0;
            last_energy <= 8'h0;
            therapy_done <= 1'b0;
          end
          else if (class_valid && is_tach && ctrl[`STS_CTRL_ENABLE])
          begin
            // Slow-zone redetection with no slow shocks re-allows pacing
            if (ev_zone == `STS_ZONE_SLOW && !ev_cfg[`STS_ZCFG_SHOCK_EN])
              atp_blocked <= 1'b0;
            if (ev_cfg[`STS_ZCFG_SHOCK_EN] && !zone_block[ev_zone] && delivered < `STS_SHOCKS)
            begin
              state <= S_CHARGE;
              zone <= ev_zone;
              charge_on <= 1'b1;
              history <= 4'h0;
              veto <= 1'b0;
              post_shock_pace <= 1'b0;
            end
            else if (delivered >= `STS_SHOCKS)
              therapy_done <= 1'b1;
          end
        end
        S_CHARGE:
        begin
          // Rhythm watched only when confirmation is on
          if (confirm && class_valid)
          begin
            history <= {history[2:0], is_slowish};
            if (class_code == `STS_CLS_BRADY || class_code == `STS_CLS_BELOW)
              veto <= 1'b1;
          end
          if (confirm && abort_met)
          begin
            // Early stop, charge bled into the internal load
            charge_on <= 1'b0;
            dump <= 1'b1;
            state <= S_DUMP;
          end
          else if (charge_done)
          begin
            charge_on <= 1'b0;
            timer <= 32'h0;
            state <= S_WAIT;
          end
        end
        S_WAIT:
        begin
          timer <= timer + 32'h1;
          shock_energy <= next_energy;
          shock_polarity <= cfg[`STS_ZCFG_POL_LO] ^ flip_pol;
          shock_waveform <= cfg[`STS_ZCFG_WAVE_LO] ^ flip_wave;
          shock_path <= cfg[`STS_ZCFG_PATH_LO + 1 -: 2];
          if (confirm)
          begin
            if (class_valid && is_tach)
            begin
              fire <= 1'b1;
              fire_unsync <= 1'b0;
              timer <= 32'h0;
              shock_phase <= 2'h1;
              state <= S_SHOCK;
            end
            else if (timer >= WINDOW_CYC - 1 || (class_valid && class_code == `STS_CLS_BRADY))
            begin
              dump <= 1'b1;
              state <= S_DUMP;
            end
          end
          else if (r_wave || timer >= WINDOW_CYC - 1)
          begin
            fire <= 1'b1;
            fire_unsync <= ~r_wave;
            timer <= 32'h0;
            shock_phase <= 2'h1;
            state <= S_SHOCK;
          end
        end
        S_SHOCK:
        begin
          // Phase lengths capped here whatever the stage reports
          timer <= timer + 32'h1;
          if ((shock_phase == 2'h1 && (phase_done || timer >= PHASE1_CYC - 1)) ||
            (shock_phase == 2'h2 && timer >= PAUSE_CYC - 1))
          begin
            shock_phase <= shock_phase + 2'h1;
            timer <= 32'h0;
          end
          else if (shock_phase == 2'h3 && (phase_done || timer >= PHASE2_CYC - 1))
          begin
            shock_phase <= 2'h0;
            timer <= 32'h0;
            delivered <= delivered + 4'h1;
            pos <= (pos == 3'h7) ? pos : pos + 3'h1;
            last_energy <= shock_energy;
            if (shock_energy == MAX_JOULES)
              max_count <= max_count + 4'h1;
            shocked <= 1'b1;
            atp_blocked <= 1'b1;
            blanking <= 1'b1;
            state <= S_BLANK;
          end
        end
        S_BLANK:
        begin
          // Sensed events dropped while post-shock potentials settle
          timer <= timer + 32'h1;
          if (timer >= BLANK_CYC - 1)
          begin
            blanking <= 1'b0;
            state <= S_POST;
          end
        end
        S_DUMP:
        begin
          // Shock not counted; later delivery resumes no earlier than the third slot
          if (pos < `STS_SKIP_POS)
            pos <= `STS_SKIP_POS;
          state <= S_POST;
        end
        default:
          state <= S_IDLE;
      endcase
      // Accelerating therapy barred; placed last so the mark beats a clear
      if (accel_detected && state != S_IDLE)
        zone_block[zone] <= 1'b1;
    end
  end
endmodule

// ===== dv/sts_sequencer_asserts.sv
// Port checker of the shock sequencer
`timescale 1ns/1ns
module sts_chk #(
  parameter MAX_JOULES = 8'd40
) (
  // Clock, reset, bus
  input wire clock,
  input wire reset_n,
  input wire ce,
  input wire read,
  input wire write,
  input wire waitrequest,
  // Therapy side
  input wire class_valid,
  input wire charge_on,
  input wire dump,
  input wire fire,
  input wire [1:0] shock_phase,
  input wire [7:0] shock_energy,
  input wire blanking,
  input wire atp_blocked
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Bus answer, shock pulses and phases, energy range, blanking, pacing block
  property p_wait; ce && (read || write) && waitrequest |=> !waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("bus wait too long");
  property p_fire; fire |=> !fire; endproperty
  a_fire: assert property (p_fire) else $error("fire too long");
  property p_start; fire |-> shock_phase == 2'h1; endproperty
  a_start: assert property (p_start) else $error("bad first phase");
  property p_order; $changed(shock_phase) && shock_phase == 2'h3 |-> $past(shock_phase) == 2'h2; endproperty
  a_order: assert property (p_order) else $error("no pause");
  property p_dump; dump |-> !charge_on && !fire ##1 !dump; endproperty
  a_dump: assert property (p_dump) else $error("bad dump");
  property p_energy; fire |-> shock_energy >= 8'h02 && shock_energy <= MAX_JOULES; endproperty
  a_energy: assert property (p_energy) else $error("energy range");
  property p_blank; blanking && class_valid |=> !charge_on; endproperty
  a_blank: assert property (p_blank) else $error("charge in blanking");
  property p_atp; $rose(blanking) |-> atp_blocked; endproperty
  a_atp: assert property (p_atp) else $error("pacing not blocked");
  // Main scenarios reached
  c_fire: cover property (fire);
  c_dump: cover property (dump);
  c_blank: cover property ($rose(blanking));
endmodule
bind sts_sequencer sts_chk #(.MAX_JOULES(MAX_JOULES)) sts_chk_inst (.clock(clock), .reset_n(reset_n), .ce(ce),
  .read(read), .write(write), .waitrequest(waitrequest), .class_valid(class_valid), .charge_on(charge_on),
  .dump(dump), .fire(fire), .shock_phase(shock_phase), .shock_energy(shock_energy), .blanking(blanking),
  .atp_blocked(atp_blocked));

// ===== dv/sts_hv_model.sv
// High-voltage stage model for the shock sequencer bench
`timescale 1ns/1ns
module sts_hv_model (
  // Clock, reset, requests
  input wire clock,
  input wire reset_n,
  input wire charge_on,
  input wire [1:0] shock_phase,
  input wire [7:0] charge_len,
  // Answers
  output reg charge_done,
  output reg phase_done
);
  reg [7:0] ccnt;
  reg [7:0] pcnt;
  reg [1:0] lph;
  // Charge ends after charge_len cycles, each phase voltage after six; pause unanswered
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ccnt <= 8'h00;
      pcnt <= 8'h00;
      lph <= 2'h0;
      charge_done <= 1'b0;
      phase_done <= 1'b0;
    end
    else
    begin
      ccnt <= charge_on ? ccnt + 8'h01 : 8'h00;
      charge_done <= charge_on && ccnt == charge_len;
      lph <= shock_phase;
      pcnt <= (shock_phase != lph) ? 8'h00 : pcnt + 8'h01;
      phase_done <= shock_phase[0] && pcnt == 8'h05;
    end
  end
endmodule

// ===== dv/sts_sequencer_tb_top.sv
// Self-checking bench of the shock sequencer
`timescale 1ns/1ns
module sts_sequencer_tb_top;
  logic clock = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0, class_valid = 1'b0, fu;
  logic episode_end = 1'b0, r_wave = 1'b0, asystole = 1'b0, accel_detected = 1'b0, sync_on = 1'b0, alt = 1'b0;
  logic [7:0] address = 8'h00, charge_len = 8'h08, fe;
  logic [2:0] class_code = 3'h0;
  logic [31:0] writedata = 32'h0, q, seed = 32'h0001287f;
  wire waitrequest, charge_on, dump, fire, fire_unsync, blanking, atp_blocked, charge_done, phase_done;
  wire shock_polarity, shock_waveform, post_shock_pace, therapy_done;
  wire [1:0] shock_phase, shock_path;
  wire [7:0] shock_energy;
  wire [31:0] readdata;
  int mismatches = 0, n_checks = 0, fired = 0, dumped = 0, pos = 0, last = 0, nmax = 0, pth = 0, j;
  int ej[2];
  // Clock of 8 ns period
  always #4 clock = ~clock;
  // Device with short windows; clock enable held high
  sts_sequencer #(.MAX_JOULES(8'd40), .WINDOW_CYC(50), .PHASE1_CYC(20), .PAUSE_CYC(4), .PHASE2_CYC(16),
    .BLANK_CYC(30)) sts_sequencer_inst (.clock(clock), .reset_n(reset_n), .ce(1'b1), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .class_valid(class_valid), .class_code(class_code), .episode_end(episode_end), .r_wave(r_wave),
    .asystole(asystole), .accel_detected(accel_detected), .charge_done(charge_done), .phase_done(phase_done),
    .charge_on(charge_on), .dump(dump), .fire(fire), .fire_unsync(fire_unsync), .shock_phase(shock_phase),
    .shock_energy(shock_energy), .shock_polarity(shock_polarity), .shock_waveform(shock_waveform),
    .shock_path(shock_path), .blanking(blanking), .post_shock_pace(post_shock_pace), .atp_blocked(atp_blocked),
    .therapy_done(therapy_done));
  // High-voltage stage
  sts_hv_model sts_hv_model_inst (.clock(clock), .reset_n(reset_n), .charge_on(charge_on),
    .shock_phase(shock_phase), .charge_len(charge_len), .charge_done(charge_done), .phase_done(phase_done));
  // Random source for energies
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Verdict
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Compare and count
  task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", w, e, g);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    int i;
    i = 0;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    @(posedge clock);
    while (waitrequest !== 1'b0 && i < 20)
    begin
      @(posedge clock);
      i++;
    end
    // Answer edge: data taken here, request released here
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
    check("bus wait", 32'h0, i == 20);
    if (i == 20)
      end_sim;
  endtask
  // Events of one class four cycles apart; optionally stop at the first shock
  task automatic events(input logic [2:0] c, input int n, input logic stop);
    int k;
    for (k = 0; k < 4 * n && !(stop && fired > 0); k++)
    begin
      @(posedge clock);
      class_valid <= (k % 4 == 0);
      class_code <= c;
      r_wave <= sync_on && (k % 4 == 2);
      @(negedge clock);
      fe = (fire === 1'b1) ? shock_energy : fe;
      fired += (fire === 1'b1);
      dumped += (dump === 1'b1);
      fu = (fire === 1'b1) ? (fire_unsync === 1'b1) : fu;
    end
    @(posedge clock);
    class_valid <= 1'b0;
    r_wave <= 1'b0;
  endtask
  // One shock at the modelled position, then blanking and post state
  task automatic shock(input string nm, input logic un);
    int x;
    int p;
    x = pos < 2 ? ej[pos] : 40;
    x = x < last ? last : x;
    // Alternation flips from the second maximum-energy shock on
    p = (alt && x == 40) ? nmax % 2 : 0;
    nmax += (x == 40);
    fired = 0;
    fu = 1'b0;
    events(3'h5, 30, 1'b1);
    check("fired", 32'h1, fired);
    check("energy", x, fe);
    events(3'h0, 16, 1'b0);
    check("unsync", un, fu);
    check("polarity", p, shock_polarity);
    check("waveform", 32'h0, shock_waveform);
    check("path", pth, shock_path);
    last = x;
    pos++;
    $display("test %s done", nm);
  endtask
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, 8'h18, 32'h0, q);
    check("zone cfg", 32'h3, q);
    bus(1'b1, 8'h88, 32'hff, q);
    bus(1'b0, 8'h88, 32'h0, q);
    check("energy store", 32'hff, q);
    bus(1'b1, 8'h3c, 32'h5a, q);
    bus(1'b0, 8'h3c, 32'h0, q);
    check("unmapped", 32'h0, q);
    seed = lfsr(seed);
    ej[0] = 20 + seed % 21;
    seed = lfsr(seed);
    ej[1] = 2 + seed % (ej[0] - 2);
    bus(1'b1, 8'h80, ej[0], q);
    bus(1'b1, 8'h84, ej[1], q);
    bus(1'b1, 8'h00, 32'h1, q);
    shock("first", 1'b0);
    shock("second", 1'b0);
    check("atp", 32'h1, atp_blocked);
    // Abort during a long charge, then a window with no tachycardic interval
    charge_len <= 8'h28;
    dumped = 0;
    fired = 0;
    events(3'h5, 1, 1'b0);
    events(3'h0, 5, 1'b0);
    check("abort dump", 32'h1, dumped);
    pos = 2;
    charge_len <= 8'h08;
    events(3'h5, 1, 1'b0);
    events(3'h2, 25, 1'b0);
    check("window dump", 32'h2, dumped);
    check("no fire", 32'h0, fired);
    $display("test dumps done");
    // Confirmation off, polarity alternating, second shock path
    bus(1'b1, 8'h18, 32'h61, q);
    alt = 1'b1;
    pth = 1;
    shock("unconfirmed", 1'b1);
    sync_on = 1'b1;
    shock("synced", 1'b0);
    sync_on = 1'b0;
    bus(1'b0, 8'h08, 32'h0, q);
    check("delivered", 32'h4, q[11:8]);
    // Asystole asks for post-shock pacing, a sensed event withdraws it
    @(posedge clock) asystole <= 1'b1;
    @(posedge clock) asystole <= 1'b0;
    @(negedge clock) check("pace", 32'h1, post_shock_pace);
    events(3'h0, 1, 1'b0);
    check("pace off", 32'h0, post_shock_pace);
    // Acceleration bars the zone until the episode closes
    @(posedge clock) accel_detected <= 1'b1;
    @(posedge clock) accel_detected <= 1'b0;
    fired = 0;
    events(3'h5, 2, 1'b0);
    check("blocked fire", 32'h0, fired);
    bus(1'b0, 8'h04, 32'h0, q);
    check("zone block", 32'h4, q[16:14]);
    @(posedge clock) episode_end <= 1'b1;
    @(posedge clock) episode_end <= 1'b0;
    bus(1'b0, 8'h04, 32'h0, q);
    check("episode end", 32'h0, q[16:11]);
    $display("test episode done");
    // Fresh episode run to exhaustion
    pos = 0;
    last = 0;
    nmax = 0;
    for (j = 0; j < 8; j++)
      shock("refill", 1'b1);
    events(3'h5, 1, 1'b0);
    check("exhausted", 32'h1, therapy_done);
    end_sim;
  end
endmodule
